// ---- design/lbr_top.sv ----
// Purpose: enables of regulators three and four, regulator four voltage select,
//          buck reference codes and operating modes
// Assumes: command port is the decoded output of the serial command interface
// Notes:   pins and loop events are asynchronous and pass two flip-flops
`timescale 1ns/1ns
`default_nettype none
`include "lbr_defines.svh"

// Functional notes
// - regulator three on by pin or enable bit
// - regulator three start wait bit, variant two inverted
// - base variant regulator four voltage code table
// - other variants regulator four voltage code table
// - pin low: enable bits drive three, four
// - base: pair pin switches both together
// - decouple bit: regulator four follows bit only
// - variants one, two: pin drives three only
// - regulator four start wait bit, variant two inverted
// - buck reference equals offset plus step times code
// - buck target codes reset to 11001
// - command bits take defaults at reset
// - three modes, independent per converter
// - downward slew forces forced continuous mode
// - switch latch set each cycle, cleared on trip
// - select bit picks target a or b
module lbr_top #(
	parameter lbr_pkg::lbr_variant_type VARIANT = lbr_pkg::LBR_VAR_BASE,
	parameter int SLEW_DIV = `LBR_SLEW_DIV
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// command register port
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic [7:0] cmd_addr_i,
	input wire logic [7:0] cmd_wdata_i,
	output logic [7:0] cmd_rdata_o,
	output logic cmd_rvalid_o,
	// enable pins
	input wire logic pair_enable_pin_i,
	input wire logic single_enable_pin_i,
	// converter loop events, one per converter
	input wire logic [2:0] cycle_start_i,
	input wire logic [2:0] peak_trip_i,
	// regulators three and four
	output logic regulator_three_en_o,
	output logic regulator_four_en_o,
	output logic regulator_three_wait_low_o,
	output logic regulator_four_wait_low_o,
	output logic [1:0] regulator_four_vsel_o,
	output logic [11:0] regulator_four_mv_o,
	// step-down converters
	output logic [2:0][4:0] buck_ref_code_o,
	output logic [2:0][12:0] buck_ref_tenth_mv_o,
	output lbr_pkg::lbr_mode_type [2:0] buck_mode_o,
	output logic [2:0] buck_slew_down_o,
	output logic [2:0] buck_switch_on_o
);
	import lbr_pkg::*;

	// ======================================================================
	// helpers
	function automatic logic [11:0] r4_mv(input logic [1:0] vsel, input logic alt);
		logic [11:0] mv;
		mv = 12'h000;
		if (!alt) begin
			unique case (vsel)
				2'b00: mv = `LBR_R4_BASE_00;
				2'b01: mv = `LBR_R4_BASE_01;
				2'b10: mv = `LBR_R4_BASE_10;
				2'b11: mv = `LBR_R4_BASE_11;
			endcase
		end else begin
			unique case (vsel)
				2'b00: mv = `LBR_R4_ALT_00;
				2'b01: mv = `LBR_R4_ALT_01;
				2'b10: mv = `LBR_R4_ALT_10;
				2'b11: mv = `LBR_R4_ALT_11;
			endcase
		end
		r4_mv = mv;
	endfunction

	// start bit meaning: 0 waits on base and variant one, inverted on two
	function automatic logic wait_low(input logic bit_val);
		wait_low = (VARIANT == LBR_VAR_TWO) ? bit_val : ~bit_val;
	endfunction

	localparam logic IS_BASE = (VARIANT == LBR_VAR_BASE);

	// ======================================================================
	// pin and loop event synchronisers
	logic [7:0] sync1_reg, sync1_next;
	logic [7:0] sync2_reg, sync2_next;
	logic pair_pin_s, single_pin_s;
	logic [2:0] cycle_start_s, peak_trip_s;

	always_comb begin
		sync1_next = {peak_trip_i, cycle_start_i, single_enable_pin_i, pair_enable_pin_i};
		sync2_next = sync1_reg;
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	assign pair_pin_s = sync2_reg[0];
	assign single_pin_s = sync2_reg[1];
	assign cycle_start_s = sync2_reg[4:2];
	assign peak_trip_s = sync2_reg[7:5];

	// ======================================================================
	// command registers
	logic [7:0] out_en_reg, out_en_next;
	logic [7:0] start_wait_reg, start_wait_next;
	logic [7:0] tgt_b_cfg_reg, tgt_b_cfg_next;
	logic [5:0] sw_mode_reg, sw_mode_next;
	logic [2:0] buck_sel_reg, buck_sel_next;
	logic [2:0][4:0] tgt_a_reg, tgt_a_next;
	logic [2:0][4:0] tgt_b_reg, tgt_b_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [7:0] status_val;

	always_comb begin
		out_en_next = out_en_reg;
		start_wait_next = start_wait_reg;
		tgt_b_cfg_next = tgt_b_cfg_reg;
		sw_mode_next = sw_mode_reg;
		buck_sel_next = buck_sel_reg;
		tgt_a_next = tgt_a_reg;
		tgt_b_next = tgt_b_reg;
		if (cmd_wr_i) begin
			unique case (cmd_addr_i)
				`LBR_ADDR_OUT_EN: out_en_next = cmd_wdata_i;
				`LBR_ADDR_START_WAIT: start_wait_next = cmd_wdata_i;
				`LBR_ADDR_LDO_TGT_B: tgt_b_cfg_next = cmd_wdata_i;
				`LBR_ADDR_SW_MODE: sw_mode_next = cmd_wdata_i[5:0];
				`LBR_ADDR_BUCK_SEL: buck_sel_next = cmd_wdata_i[2:0];
				`LBR_ADDR_BUCK_A_BASE: tgt_a_next[0] = cmd_wdata_i[4:0];
				`LBR_ADDR_BUCK_A_BASE + 8'h01: tgt_a_next[1] = cmd_wdata_i[4:0];
				`LBR_ADDR_BUCK_A_BASE + 8'h02: tgt_a_next[2] = cmd_wdata_i[4:0];
				`LBR_ADDR_BUCK_B_BASE: tgt_b_next[0] = cmd_wdata_i[4:0];
				`LBR_ADDR_BUCK_B_BASE + 8'h01: tgt_b_next[1] = cmd_wdata_i[4:0];
				`LBR_ADDR_BUCK_B_BASE + 8'h02: tgt_b_next[2] = cmd_wdata_i[4:0];
				default: ;
			endcase
		end
	end

	// status: live enables, start waits and downward slews
	assign status_val = {1'b0, buck_slew_down_o, regulator_four_wait_low_o,
		regulator_three_wait_low_o, regulator_four_en_o, regulator_three_en_o};

	always_comb begin
		rvalid_next = cmd_rd_i;
		rdata_next = rdata_reg;
		if (cmd_rd_i) begin
			unique case (cmd_addr_i)
				`LBR_ADDR_OUT_EN: rdata_next = out_en_reg;
				`LBR_ADDR_START_WAIT: rdata_next = start_wait_reg;
				`LBR_ADDR_LDO_TGT_B: rdata_next = tgt_b_cfg_reg;
				`LBR_ADDR_SW_MODE: rdata_next = {2'b00, sw_mode_reg};
				`LBR_ADDR_BUCK_SEL: rdata_next = {5'h00, buck_sel_reg};
				`LBR_ADDR_BUCK_A_BASE: rdata_next = {3'h0, tgt_a_reg[0]};
				`LBR_ADDR_BUCK_A_BASE + 8'h01: rdata_next = {3'h0, tgt_a_reg[1]};
				`LBR_ADDR_BUCK_A_BASE + 8'h02: rdata_next = {3'h0, tgt_a_reg[2]};
				`LBR_ADDR_BUCK_B_BASE: rdata_next = {3'h0, tgt_b_reg[0]};
				`LBR_ADDR_BUCK_B_BASE + 8'h01: rdata_next = {3'h0, tgt_b_reg[1]};
				`LBR_ADDR_BUCK_B_BASE + 8'h02: rdata_next = {3'h0, tgt_b_reg[2]};
				`LBR_ADDR_STATUS: rdata_next = status_val;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			out_en_reg <= `LBR_OUT_EN_RST;
			start_wait_reg <= `LBR_START_WAIT_RST;
			tgt_b_cfg_reg <= `LBR_LDO_TGT_B_RST;
			sw_mode_reg <= `LBR_SW_MODE_RST;
			buck_sel_reg <= `LBR_BUCK_SEL_RST;
			tgt_a_reg <= {3{`LBR_BUCK_CODE_RST}};
			tgt_b_reg <= {3{`LBR_BUCK_CODE_RST}};
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			out_en_reg <= out_en_next;
			start_wait_reg <= start_wait_next;
			tgt_b_cfg_reg <= tgt_b_cfg_next;
			sw_mode_reg <= sw_mode_next;
			buck_sel_reg <= buck_sel_next;
			tgt_a_reg <= tgt_a_next;
			tgt_b_reg <= tgt_b_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign cmd_rdata_o = rdata_reg;
	assign cmd_rvalid_o = rvalid_reg;

	// ======================================================================
	// regulator three and four control
	logic r3_en_reg, r3_en_next;
	logic r4_en_reg, r4_en_next;
	logic r3_wait_reg, r3_wait_next;
	logic r4_wait_reg, r4_wait_next;
	logic [1:0] r4_vsel_reg, r4_vsel_next;
	logic [11:0] r4_mv_reg, r4_mv_next;
	logic oe3, oe4, decouple4;

	assign oe3 = out_en_reg[`LBR_OE_REG3_BIT];
	assign oe4 = out_en_reg[`LBR_OE_REG4_BIT];
	assign decouple4 = tgt_b_cfg_reg[`LBR_TB_DECOUPLE_BIT];

	always_comb begin
		if (IS_BASE) begin
			// pin low leaves each regulator to its own enable bit
			r3_en_next = pair_pin_s | oe3;
			r4_en_next = oe4 | (pair_pin_s & ~decouple4);
		end else begin
			// decouple bit has no function on these variants
			r3_en_next = single_pin_s | oe3;
			r4_en_next = oe4;
		end
		r3_wait_next = wait_low(start_wait_reg[`LBR_SW_REG3_BIT]);
		r4_wait_next = wait_low(start_wait_reg[`LBR_SW_REG4_BIT]);
		r4_vsel_next = tgt_b_cfg_reg[`LBR_TB_VSEL_HI:`LBR_TB_VSEL_LO];
		r4_mv_next = r4_mv(r4_vsel_next, !IS_BASE);
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			r3_en_reg <= 1'b0;
			r4_en_reg <= 1'b0;
			r3_wait_reg <= 1'b0;
			r4_wait_reg <= 1'b0;
			r4_vsel_reg <= 2'b00;
			r4_mv_reg <= 12'h000;
		end else begin
			r3_en_reg <= r3_en_next;
			r4_en_reg <= r4_en_next;
			r3_wait_reg <= r3_wait_next;
			r4_wait_reg <= r4_wait_next;
			r4_vsel_reg <= r4_vsel_next;
			r4_mv_reg <= r4_mv_next;
		end
	end

	assign regulator_three_en_o = r3_en_reg;
	assign regulator_four_en_o = r4_en_reg;
	assign regulator_three_wait_low_o = r3_wait_reg;
	assign regulator_four_wait_low_o = r4_wait_reg;
	assign regulator_four_vsel_o = r4_vsel_reg;
	assign regulator_four_mv_o = r4_mv_reg;

	// ======================================================================
	// reference slew pacing
	logic [7:0] div_reg, div_next;
	logic tick_reg, tick_next;

	always_comb begin
		if (div_reg == 8'(SLEW_DIV - 1)) begin
			div_next = 8'h00;
			tick_next = 1'b1;
		end else begin
			div_next = div_reg + 8'h01;
			tick_next = 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			div_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	// ======================================================================
	// step-down converters
	for (genvar i = 0; i < 3; i++) begin : g_buck
		logic [4:0] target;
		assign target = buck_sel_reg[i] ? tgt_b_reg[i] : tgt_a_reg[i];

		lbr_buck_chan u_chan (
			.clock_i(clock_i),
			.rstn_i(rstn_i),
			.target_code_i(target),
			.mode_sel_i(lbr_mode_type'(sw_mode_reg[2*i +: 2])),
			.step_tick_i(tick_reg),
			.cycle_start_i(cycle_start_s[i]),
			.peak_trip_i(peak_trip_s[i]),
			.ref_code_o(buck_ref_code_o[i]),
			.ref_tenth_mv_o(buck_ref_tenth_mv_o[i]),
			.mode_o(buck_mode_o[i]),
			.slew_down_o(buck_slew_down_o[i]),
			.switch_on_o(buck_switch_on_o[i])
		);
	end

endmodule
`default_nettype wire

// ---- design/lbr_defines.svh ----
// Purpose: offsets, field positions, reset values and timing counts for the
//          ldo enable and buck reference control block
// Assumes: 8-bit command registers reached through the command port
// Notes:   definitions only
`ifndef LBR_DEFINES_SVH
`define LBR_DEFINES_SVH

// ==========================================================================
// command register offsets
`define LBR_ADDR_OUT_EN 8'h00
`define LBR_ADDR_START_WAIT 8'h01
`define LBR_ADDR_LDO_TGT_B 8'h02
`define LBR_ADDR_SW_MODE 8'h03
`define LBR_ADDR_BUCK_SEL 8'h04
`define LBR_ADDR_BUCK_A_BASE 8'h10
`define LBR_ADDR_BUCK_B_BASE 8'h13
`define LBR_ADDR_STATUS 8'h20

// ==========================================================================
// field positions
`define LBR_OE_REG3_BIT 5
`define LBR_OE_REG4_BIT 6
`define LBR_SW_REG3_BIT 5
`define LBR_SW_REG4_BIT 6
`define LBR_TB_VSEL_HI 6
`define LBR_TB_VSEL_LO 5
`define LBR_TB_DECOUPLE_BIT 7

// ==========================================================================
// reset values
`define LBR_OUT_EN_RST 8'h00
`define LBR_START_WAIT_RST 8'h00
`define LBR_LDO_TGT_B_RST 8'h19
`define LBR_SW_MODE_RST 6'h00
`define LBR_BUCK_SEL_RST 3'h0
`define LBR_BUCK_CODE_RST 5'h19

// ==========================================================================
// regulator four output in mV, base variant then variants one and two
`define LBR_R4_BASE_00 12'haf0
`define LBR_R4_BASE_01 12'h9c4
`define LBR_R4_BASE_10 12'h708
`define LBR_R4_BASE_11 12'hce4
`define LBR_R4_ALT_00 12'h4b0
`define LBR_R4_ALT_01 12'h708
`define LBR_R4_ALT_10 12'h9c4
`define LBR_R4_ALT_11 12'hc80

// buck reference in units of 0.1 mV: offset plus step times code
`define LBR_REF_OFFSET 13'he29
`define LBR_REF_STEP 13'h07d

// ==========================================================================
// timing: clock cycles between reference slew steps
`define LBR_SLEW_DIV 16

`endif

// ---- design/lbr_pkg.sv ----
// Purpose: shared types of the ldo enable and buck reference control block
// Assumes: nothing beyond the defines header
// Notes:   types only; numbers live in lbr_defines.svh
package lbr_pkg;

	// ======================================================================
	// device variant
	typedef enum logic [1:0] {
		LBR_VAR_BASE = 2'b00,
		LBR_VAR_ONE = 2'b01,
		LBR_VAR_TWO = 2'b10
	} lbr_variant_type;

	// ======================================================================
	// converter operating mode
	typedef enum logic [1:0] {
		LBR_MODE_PSKIP = 2'b00,
		LBR_MODE_LOWPWR = 2'b01,
		LBR_MODE_FCONT = 2'b10,
		LBR_MODE_RSVD = 2'b11
	} lbr_mode_type;

endpackage

// ---- design/lbr_buck_chan.sv ----
// Purpose: one step-down converter: reference slew, effective mode, switch latch
// Assumes: cycle_start_i and peak_trip_i already synchronised to clock_i
// Notes:   reference walks one code per step tick toward the selected target
`timescale 1ns/1ns
`default_nettype none
`include "lbr_defines.svh"

module lbr_buck_chan (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// configuration
	input wire logic [4:0] target_code_i,
	input wire lbr_pkg::lbr_mode_type mode_sel_i,
	input wire logic step_tick_i,
	// loop events
	input wire logic cycle_start_i,
	input wire logic peak_trip_i,
	// results
	output logic [4:0] ref_code_o,
	output logic [12:0] ref_tenth_mv_o,
	output lbr_pkg::lbr_mode_type mode_o,
	output logic slew_down_o,
	output logic switch_on_o
);
	import lbr_pkg::*;

	function automatic logic [12:0] ref_of(input logic [4:0] code);
		ref_of = `LBR_REF_OFFSET + `LBR_REF_STEP * {8'h00, code};
	endfunction

	logic [4:0] code_reg, code_next;
	logic [12:0] mv_reg, mv_next;
	lbr_mode_type mode_reg, mode_next;
	logic down_reg, down_next;
	logic sw_reg, sw_next;

	always_comb begin
		code_next = code_reg;
		if (step_tick_i) begin
			if (code_reg > target_code_i) begin
				code_next = code_reg - 5'h01;
			end else if (code_reg < target_code_i) begin
				code_next = code_reg + 5'h01;
			end
		end
		mv_next = ref_of(code_next);
		down_next = code_next > target_code_i;
		// downward slew must sink current, so programmed mode is overridden
		if (down_next) begin
			mode_next = LBR_MODE_FCONT;
		end else begin
			unique case (mode_sel_i)
				LBR_MODE_PSKIP: mode_next = LBR_MODE_PSKIP;
				LBR_MODE_LOWPWR: mode_next = LBR_MODE_LOWPWR;
				LBR_MODE_FCONT: mode_next = LBR_MODE_FCONT;
				LBR_MODE_RSVD: mode_next = LBR_MODE_PSKIP;
			endcase
		end
		// peak trip wins over a coincident cycle start to bound current
		if (peak_trip_i) begin
			sw_next = 1'b0;
		end else if (cycle_start_i) begin
			sw_next = 1'b1;
		end else begin
			sw_next = sw_reg;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			code_reg <= `LBR_BUCK_CODE_RST;
			mv_reg <= ref_of(`LBR_BUCK_CODE_RST);
			mode_reg <= LBR_MODE_PSKIP;
			down_reg <= 1'b0;
			sw_reg <= 1'b0;
		end else begin
			code_reg <= code_next;
			mv_reg <= mv_next;
			mode_reg <= mode_next;
			down_reg <= down_next;
			sw_reg <= sw_next;
		end
	end

	assign ref_code_o = code_reg;
	assign ref_tenth_mv_o = mv_reg;
	assign mode_o = mode_reg;
	assign slew_down_o = down_reg;
	assign switch_on_o = sw_reg;

endmodule
`default_nettype wire

// ---- test/lbr_host_model.sv ----
// Purpose: command host on the far side of the register port
// Assumes: one-cycle strobes, read answer exactly one cycle later
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none

module lbr_host_model (
	// clock
	input wire logic clock_i,
	// command port toward the block
	output logic cmd_wr_o,
	output logic cmd_rd_o,
	output logic [7:0] cmd_addr_o,
	output logic [7:0] cmd_wdata_o,
	input wire logic [7:0] cmd_rdata_i,
	input wire logic cmd_rvalid_i
);
	initial begin
		cmd_wr_o = 1'b0;
		cmd_rd_o = 1'b0;
		cmd_addr_o = 8'h00;
		cmd_wdata_o = 8'h00;
	end

	// ========
	// transfers
	// callers interleave enable and configuration writes
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		cmd_wr_o = 1'b1;
		cmd_addr_o = a;
		cmd_wdata_o = d;
		@(posedge clock_i);
		#1;
		cmd_wr_o = 1'b0;
		cmd_addr_o = ~a;
		cmd_wdata_o = ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clock_i);
		#1;
		cmd_rd_o = 1'b1;
		cmd_addr_o = a;
		@(posedge clock_i);
		#1;
		cmd_rd_o = 1'b0;
		cmd_addr_o = ~a;
		if (cmd_rvalid_i === 1'b1) begin
			ok = 1'b1;
			d = cmd_rdata_i;
		end
	endtask
endmodule
`default_nettype wire

// ---- test/lbr_top_monitor.sv ----
// Purpose: port-level assertions on the control block
// Assumes: inputs change shortly after the rising edge
// Notes:   pins pass two sync flops and one output flop
`timescale 1ns/1ns
`default_nettype none

module lbr_top_monitor #(
	parameter lbr_pkg::lbr_variant_type VARIANT = lbr_pkg::LBR_VAR_BASE
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// observed ports
	input wire logic cmd_rd_i,
	input wire logic cmd_rvalid_o,
	input wire logic pair_enable_pin_i,
	input wire logic [2:0] cycle_start_i,
	input wire logic [2:0] peak_trip_i,
	input wire logic regulator_three_en_o,
	input wire logic [1:0] regulator_four_vsel_o,
	input wire logic [11:0] regulator_four_mv_o,
	input wire logic [2:0][4:0] buck_ref_code_o,
	input wire logic [2:0][12:0] buck_ref_tenth_mv_o,
	input wire lbr_pkg::lbr_mode_type [2:0] buck_mode_o,
	input wire logic [2:0] buck_slew_down_o,
	input wire logic [2:0] buck_switch_on_o
);
	import lbr_pkg::*;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	function automatic logic [11:0] mv_of(input logic [1:0] v);
		logic [47:0] t;
		t = (VARIANT == LBR_VAR_BASE) ? 48'hce4708_9c4af0 : 48'hc809c4_7084b0;
		return t[v*12 +: 12];
	endfunction

	// ========
	// latch events, seen three edges late
	sequence s_start_seen;
		$past(cycle_start_i[0], 3) && !$past(peak_trip_i[0], 3) && $past(rstn_i, 4);
	endsequence
	sequence s_trip_seen;
		$past(peak_trip_i[0], 3) && $past(rstn_i, 4);
	endsequence

	// ========
	// assertions
	a_rvalid_after_rd: assert property (cmd_rd_i |=> cmd_rvalid_o)
		else $error("read not answered");
	a_rvalid_has_cause: assert property (cmd_rvalid_o |-> $past(cmd_rd_i))
		else $error("read answer without request");
	a_ref_formula: assert property (
		buck_ref_tenth_mv_o[0] == 13'he29 + 13'h07d * buck_ref_code_o[0]
		&& buck_ref_tenth_mv_o[1] == 13'he29 + 13'h07d * buck_ref_code_o[1]
		&& buck_ref_tenth_mv_o[2] == 13'he29 + 13'h07d * buck_ref_code_o[2])
		else $error("reference value off code");
	a_slew_forces_fc: assert property (buck_slew_down_o[0] |-> buck_mode_o[0] == LBR_MODE_FCONT)
		else $error("downward slew not forced continuous");
	a_slew_down_ends: assert property ($rose(buck_slew_down_o[0]) |-> ##[1:600] !buck_slew_down_o[0])
		else $error("downward slew never ends");
	a_four_mv_table: assert property (
		$past(rstn_i, 3) && $stable(regulator_four_vsel_o)
		&& $past(regulator_four_vsel_o) == $past(regulator_four_vsel_o, 2)
		|-> regulator_four_mv_o == mv_of(regulator_four_vsel_o))
		else $error("regulator four voltage off table");
	a_latch_set: assert property (s_start_seen |-> buck_switch_on_o[0])
		else $error("switch latch not set");
	a_latch_clear: assert property (s_trip_seen |-> !buck_switch_on_o[0])
		else $error("switch latch not cleared");
	a_pair_pin_three: assert property (
		VARIANT == LBR_VAR_BASE && $past(pair_enable_pin_i, 3)
		&& $past(rstn_i, 4) |-> regulator_three_en_o)
		else $error("pair pin does not enable three");
endmodule

bind lbr_top lbr_top_monitor #(.VARIANT(VARIANT)) u_mon (.clock_i, .rstn_i, .cmd_rd_i,
	.cmd_rvalid_o, .pair_enable_pin_i, .cycle_start_i, .peak_trip_i, .regulator_three_en_o,
	.regulator_four_vsel_o, .regulator_four_mv_o, .buck_ref_code_o, .buck_ref_tenth_mv_o,
	.buck_mode_o, .buck_slew_down_o, .buck_switch_on_o);
`default_nettype wire

// ---- test/test_lbr_top.sv ----
// Purpose: self-checking bench of the control block, base variant and variant two
// Assumes: slew pacing shortened to two clocks per code
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none

module test_lbr_top;
	import lbr_pkg::*;

	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic cmd_wr, cmd_rd, cmd_rvalid, pair, single, en3, en4, w3, w4;
	logic [7:0] cmd_addr, cmd_wdata, cmd_rdata;
	logic [2:0] cs = 3'h0;
	logic [2:0] pt = 3'h0;
	logic [2:0] slew, sw_on;
	logic [1:0] vsel;
	logic [11:0] mv;
	logic [2:0][4:0] code;
	logic [2:0][12:0] tenth;
	lbr_mode_type [2:0] mode;
	logic [11:0] mv_tab [4] = '{12'haf0, 12'h9c4, 12'h708, 12'hce4};
	logic [11:0] mv_alt [4] = '{12'h4b0, 12'h708, 12'h9c4, 12'hc80};
	logic en3b, en4b, w3b, w4b;
	logic [11:0] mvb;
	int mismatches = 0;
	int num_checks = 0;

	initial begin
		forever #4 clock_i = ~clock_i;
	end

	lbr_host_model host (.clock_i(clock_i), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd),
		.cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata), .cmd_rdata_i(cmd_rdata),
		.cmd_rvalid_i(cmd_rvalid));

	lbr_top #(.VARIANT(LBR_VAR_BASE), .SLEW_DIV(2)) dut (.clock_i(clock_i), .rstn_i(rstn_i),
		.cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
		.cmd_rdata_o(cmd_rdata), .cmd_rvalid_o(cmd_rvalid), .pair_enable_pin_i(pair),
		.single_enable_pin_i(single), .cycle_start_i(cs), .peak_trip_i(pt),
		.regulator_three_en_o(en3), .regulator_four_en_o(en4),
		.regulator_three_wait_low_o(w3), .regulator_four_wait_low_o(w4),
		.regulator_four_vsel_o(vsel), .regulator_four_mv_o(mv), .buck_ref_code_o(code),
		.buck_ref_tenth_mv_o(tenth), .buck_mode_o(mode), .buck_slew_down_o(slew),
		.buck_switch_on_o(sw_on));

	// variant two beside the base one, same commands and pins
	lbr_top #(.VARIANT(LBR_VAR_TWO), .SLEW_DIV(2)) dut2 (.clock_i(clock_i), .rstn_i(rstn_i),
		.cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
		.cmd_rdata_o(), .cmd_rvalid_o(), .pair_enable_pin_i(pair),
		.single_enable_pin_i(single), .cycle_start_i(cs), .peak_trip_i(pt),
		.regulator_three_en_o(en3b), .regulator_four_en_o(en4b),
		.regulator_three_wait_low_o(w3b), .regulator_four_wait_low_o(w4b),
		.regulator_four_vsel_o(), .regulator_four_mv_o(mvb), .buck_ref_code_o(),
		.buck_ref_tenth_mv_o(), .buck_mode_o(), .buck_slew_down_o(),
		.buck_switch_on_o());

	// ========
	// helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.read_reg(a, d, ok);
		check(ok, 1'b1);
		check(d, exp);
	endtask

	task automatic wait_code(input int i, input logic [4:0] t);
		int n;
		for (n = 0; n < 200 && code[i] !== t; n++) cyc(1);
		if (code[i] !== t) begin
			mismatches++;
			$display("unexpected at %0t: code wait ran out", $time);
			print_verdict();
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ========
	// sequence
	initial begin
		pair = 1'b0;
		single = 1'b0;
		cyc(12);
		rstn_i = 1'b1;
		cyc(4);
		check(code[0], 5'h19);
		check(tenth[2], 13'h1a5e);
		check(mv, 12'haf0);
		check(mvb, 12'h4b0);
		check({w4b, w3b, w4, w3}, 4'b0011);
		check({en4, en3}, 2'b00);
		rd_chk(8'h00, 8'h00);
		rd_chk(8'h01, 8'h00);
		rd_chk(8'h02, 8'h19);
		rd_chk(8'h10, 8'h19);
		rd_chk(8'h15, 8'h19);
		rd_chk(8'hff, 8'h00);
		rd_chk(8'h20, 8'h0c);
		$display("test reset done");
		host.write_reg(8'h00, 8'h20);
		cyc(2);
		check({en4, en3}, 2'b01);
		host.write_reg(8'h00, 8'h40);
		cyc(2);
		check({en4, en3}, 2'b10);
		rd_chk(8'h00, 8'h40);
		host.write_reg(8'h00, 8'h00);
		pair = 1'b1;
		cyc(4);
		check({en4b, en3b, en4, en3}, 4'b0011);
		host.write_reg(8'h02, 8'h99);
		cyc(2);
		check({en4b, en3b, en4, en3}, 4'b0001);
		host.write_reg(8'h00, 8'h40);
		cyc(2);
		check({en4b, en3b, en4, en3}, 4'b1011);
		host.write_reg(8'h00, 8'h00);
		pair = 1'b0;
		single = 1'b1;
		cyc(4);
		// single pin has no say on the base variant
		check({en4b, en3b, en4, en3}, 4'b0100);
		$display("test enables done");
		for (int i = 0; i < 4; i++) begin
			host.write_reg(8'h02, {1'b0, i[1:0], 5'h19});
			cyc(3);
			check(vsel, i[1:0]);
			check(mv, mv_tab[i]);
			check(mvb, mv_alt[i]);
		end
		host.write_reg(8'h01, 8'h60);
		cyc(2);
		check({w4b, w3b, w4, w3}, 4'b1100);
		host.write_reg(8'h01, 8'h20);
		cyc(2);
		check({w4b, w3b, w4, w3}, 4'b0110);
		$display("test regulator four done");
		host.write_reg(8'h03, 8'h24);
		cyc(2);
		check(mode, 6'h24);
		host.write_reg(8'h10, 8'h10);
		cyc(3);
		check(slew[0], 1'b1);
		check(mode[0], LBR_MODE_FCONT);
		rd_chk(8'h20, 8'h18);
		wait_code(0, 5'h10);
		cyc(1);
		check(tenth[0], 13'h15f9);
		check({slew[0], mode[0]}, {1'b0, LBR_MODE_PSKIP});
		host.write_reg(8'h14, 8'h1f);
		host.write_reg(8'h04, 8'h02);
		cyc(3);
		// upward slew keeps the programmed mode
		check({slew[1], mode[1]}, {1'b0, LBR_MODE_LOWPWR});
		wait_code(1, 5'h1f);
		check(tenth[1], 13'h1d4c);
		check(code[2], 5'h19);
		// reserved mode code runs as pulse skip
		host.write_reg(8'h03, 8'h34);
		cyc(2);
		check(mode, 6'h04);
		$display("test converters done");
		cs = 3'b001;
		cyc(1);
		cs = 3'b000;
		cyc(3);
		check(sw_on, 3'b001);
		pt = 3'b001;
		cyc(1);
		pt = 3'b000;
		cyc(3);
		check(sw_on, 3'b000);
		$display("test latch done");
		print_verdict();
	end
endmodule
`default_nettype wire
